// file: rtl/sdpr_params.svh
// sdpr_params.svh: offsets, fields, reset values and timing counts
// assumes: included by bare name after the package is compiled
`ifndef SDPR_PARAMS_SVH
`define SDPR_PARAMS_SVH

// clock rate and timing figures
`define SDPR_CLK_MHZ      25
`define SDPR_T_RP_NS      20
`define SDPR_T_RAS_NS     45
`define SDPR_T_WR_NS      15
`define SDPR_T_RFC_NS     80
`define SDPR_CYC_MIN(ns)  ((((ns) * `SDPR_CLK_MHZ) + 999) / 1000)

// register offsets
`define SDPR_REG_CFG      4'h0
`define SDPR_REG_STAT     4'h4
`define SDPR_REG_ROW      4'h8

// configuration fields
`define SDPR_CFG_BL_LSB   0
`define SDPR_CFG_CL_LSB   4
`define SDPR_CFG_WBM_BIT  9
`define SDPR_CFG_RESET    16'h0022
`define SDPR_BL_CONT      3'h7
`define SDPR_AP_BIT       10
`define SDPR_WR_CONT_LEN  8'hff

`endif

// file: rtl/sdpr_pkg.sv
// sdpr_pkg.sv: types of the bank-state logic
// assumes: nothing
package sdpr_pkg;

	typedef enum logic [2:0] {
		SDPR_NOP, SDPR_ACT, SDPR_RD, SDPR_WR, SDPR_PRE, SDPR_REF, SDPR_OTHER
	} sdpr_cmd_e;

	typedef enum logic [2:0] {
		BK_IDLE, BK_ACTIVE, BK_BURST, BK_WREC, BK_ARMED, BK_PRECH
	} sdpr_bank_e;

	typedef logic [11:0] sdpr_row_t;

	typedef struct packed {
		sdpr_bank_e st;
		logic [7:0] ras;
		logic [7:0] cnt;
		logic       wr;
	} sdpr_bank_s;

	typedef struct packed {
		logic       busy;
		logic [7:0] cnt;
		sdpr_row_t  row;
		sdpr_row_t  ctr;
	} sdpr_ref_s;

	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] rdata;
		logic [3:0]  open;
		logic [3:0]  idle;
		logic [3:0]  autoPend;
		logic        refBusy;
		sdpr_row_t   refRow;
		logic [7:0]  wrLeft;
		logic        wrCont;
		logic [1:0]  wrCurBank;
		logic        wrStore;
		logic [1:0]  wrStoreBank;
		logic [7:0]  rdLeft;
		logic        rdCont;
		logic [1:0]  rdCurBank;
		logic [1:0]  rdPipe;
		logic [3:0]  rdBankPipe;
		logic [1:0]  dqmPipe;
		logic        rdValid;
		logic [1:0]  rdBank;
		logic        cmdError;
	} sdpr_top_s;

endpackage : sdpr_pkg

// file: rtl/sdpr_bank.sv
// sdpr_bank.sv: open/idle state and precharge timers of one bank
// assumes: commands already decoded and checked by the parent
module sdpr_bank #(
	parameter int TRP  = 1,
	parameter int TRAS = 2,
	parameter int TWR  = 1
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// decoded requests
	input  wire logic       activate,
	input  wire logic       precharge,
	input  wire logic       access,
	input  wire logic       accWrite,
	input  wire logic       accAuto,
	input  wire logic       accCont,
	input  wire logic [7:0] accLen,
	input  wire logic       interrupt,
	// state
	output logic            open,
	output logic            idle,
	output logic            autoPending
);
	import sdpr_pkg::*;

	localparam logic [7:0] TRP_C  = 8'(TRP - 1);
	localparam logic [7:0] TRAS_C = 8'(TRAS - 1);
	localparam logic [7:0] TWR_C  = 8'(TWR - 1);

	sdpr_bank_s q;
	sdpr_bank_s next_q;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_q = q;
		if (q.ras != 8'h00) begin
			next_q.ras = q.ras - 8'h01;
		end
		case (q.st)
			BK_IDLE: begin
				if (activate) begin
					next_q.st  = BK_ACTIVE;
					next_q.ras = TRAS_C;
				end
			end
			BK_ACTIVE: begin
				if (access && accAuto && !accCont) begin // RQ5 RQ6
					next_q.st  = BK_BURST;
					next_q.cnt = accLen - 8'h01;
					next_q.wr  = accWrite;
				end
			end
			BK_BURST: begin
				if (interrupt && q.wr) begin // RQ13 RQ15
					next_q.st  = BK_WREC;
					next_q.cnt = TWR_C;
				end else if (interrupt) begin // RQ10 RQ11
					next_q.st = BK_ARMED;
				end else if (q.cnt == 8'h00 && q.wr) begin // RQ4
					next_q.st  = BK_WREC;
					next_q.cnt = TWR_C;
				end else if (q.cnt == 8'h00) begin // RQ4
					next_q.st = BK_ARMED;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			BK_WREC: begin
				if (q.cnt == 8'h00) begin
					next_q.st = BK_ARMED;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			BK_ARMED: begin
				if (q.ras == 8'h00) begin // RQ9
					next_q.st  = BK_PRECH;
					next_q.cnt = TRP_C;
				end
			end
			BK_PRECH: begin
				if (q.cnt == 8'h00) begin // RQ3
					next_q.st = BK_IDLE;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			default: begin
				next_q.st = BK_IDLE;
			end
		endcase
		if (precharge && q.st != BK_IDLE && q.st != BK_PRECH) begin // RQ1
			next_q.st  = BK_PRECH;
			next_q.cnt = TRP_C;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{st: BK_IDLE, ras: 8'h00, cnt: 8'h00, wr: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign open        = q.st != BK_IDLE && q.st != BK_PRECH;
	assign idle        = q.st == BK_IDLE;
	assign autoPending = q.st == BK_BURST || q.st == BK_WREC ||
		q.st == BK_ARMED;

	////////////////////////////////////////////////////////////////////////
	// cycle counts watched by the checks
	logic [7:0] prechCyc;
	logic [7:0] actCyc;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prechCyc <= 8'h00;
			actCyc   <= 8'h00;
		end else begin
			prechCyc <= (q.st == BK_PRECH) ? prechCyc + 8'h01 : 8'h00;
			actCyc   <= (q.st == BK_IDLE || q.st == BK_PRECH) ? 8'h00 :
				(actCyc == 8'hff ? actCyc : actCyc + 8'h01);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	rp_elapsed_a: assert property ( // RQ3
		(q.st == BK_PRECH && next_q.st == BK_IDLE) |->
			prechCyc == 8'(TRP - 1))
		else $error("bank left precharge before row-precharge time");

	ras_lockout_a: assert property ( // RQ9
		(q.st == BK_ARMED && next_q.st == BK_PRECH) |->
			actCyc >= 8'(TRAS - 1))
		else $error("auto precharge started before row-active time");

	cont_no_ap_a: assert property ( // RQ5
		(q.st == BK_ACTIVE && access && accCont && !precharge) |=>
			(q.st == BK_ACTIVE && !autoPending))
		else $error("auto precharge armed on a continuous burst");

endmodule : sdpr_bank

// file: rtl/sdpr_refresh.sv
// sdpr_refresh.sv: internal refresh row counter and refresh cycle timer
// assumes: start is only raised with all banks idle
module sdpr_refresh #(
	parameter int TRFC = 2
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// request and state
	input  wire logic       start,
	output logic            busy,
	output sdpr_pkg::sdpr_row_t row
);
	import sdpr_pkg::*;

	localparam logic [7:0] TRFC_C = 8'(TRFC - 1);

	sdpr_ref_s q;
	sdpr_ref_s next_q;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_q = q;
		if (q.busy) begin
			if (q.cnt == 8'h00) begin // RQ20
				next_q.busy = 1'b0;
			end else begin
				next_q.cnt = q.cnt - 8'h01;
			end
		end else if (start) begin
			next_q.busy = 1'b1;
			next_q.cnt  = TRFC_C;
			next_q.row  = q.ctr; // RQ17
			next_q.ctr  = q.ctr + 12'h001;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{busy: 1'b0, cnt: 8'h00, row: 12'h000, ctr: 12'h000};
		end else begin
			q <= next_q;
		end
	end

	assign busy = q.busy;
	assign row  = q.row;

	////////////////////////////////////////////////////////////////////////
	logic [7:0] busyLen;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busyLen <= 8'h00;
		end else begin
			busyLen <= q.busy ? busyLen + 8'h01 : 8'h00;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	refresh_row_a: assert property ( // RQ17
		(start && !q.busy) |=> (q.row == $past(q.ctr) &&
			q.ctr == $past(q.ctr) + 12'h001))
		else $error("refresh row not taken from internal counter");

	refresh_once_a: assert property ( // RQ20
		$fell(q.busy) |-> busyLen == 8'(TRFC))
		else $error("refresh cycle length wrong");

endmodule : sdpr_refresh

// file: rtl/sdpr_ctrl.sv
// sdpr_ctrl.sv: bank-state, auto precharge and auto refresh logic
// assumes: command pins driven on clk_sys by the memory controller,
// and a register port on the same clock
//
// Functional notes
// RQ1: precharge with A10 low closes one bank, A10 high closes all.
// RQ2: controller activates a bank before reading or writing it.
// RQ3: a bank may be activated only after row-precharge time elapses.
// RQ4: read or write with A10 high precharges the bank after the burst.
// RQ5: continuous page bursts never auto precharge.
// RQ6: single-write mode with continuous length: continuous wins, no auto.
// RQ7: auto precharge choice is taken fresh from every read or write.
// RQ8: no command to an auto-precharging bank until precharge completes.
// RQ9: single access at minimum delay holds precharge until row-active time.
// RQ10: read to other bank cuts a read after CAS latency, precharge now.
// RQ11: write to other bank cuts a read at once, precharge now.
// RQ12: controller raises data mask two clocks before interrupting write.
// RQ13: read cuts auto write; write bank precharges after write recovery.
// RQ14: write data stops one clock before the interrupting read.
// RQ15: write cuts auto write; old bank precharges after write recovery.
// RQ16: all banks precharged and idle before auto refresh.
// RQ17: refresh row comes from internal counter, address ignored.
// RQ18: only no-operation commands during the refresh cycle time.
// RQ19: every row refreshed each period, spread or in one burst.
// RQ20: each auto refresh does exactly one refresh cycle.
// RQ21: refresh period is sixty-four milliseconds.
// RQ22: single-write mode makes every write one column; reads unchanged.
// RQ23: each bank keeps its own state and precharge timer.
//
// Chosen here: the register offsets and the strobed register port.
`include "sdpr_params.svh"

module sdpr_ctrl #(
	parameter int T_RP_CYC  = `SDPR_CYC_MIN(`SDPR_T_RP_NS),
	parameter int T_RAS_CYC = `SDPR_CYC_MIN(`SDPR_T_RAS_NS),
	parameter int T_WR_CYC  = `SDPR_CYC_MIN(`SDPR_T_WR_NS),
	parameter int T_RFC_CYC = `SDPR_CYC_MIN(`SDPR_T_RFC_NS)
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// command pins
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [11:0] addr,
	input  wire logic [1:0]  ba,
	input  wire logic        dqm,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [15:0]      regRdata,
	// bank and refresh state
	output logic [3:0]       bankOpen,
	output logic [3:0]       bankIdle,
	output logic [3:0]       bankAutoPending,
	output logic             refreshBusy,
	output sdpr_pkg::sdpr_row_t refreshRow,
	// data strobes
	output logic             rdValid,
	output logic [1:0]       rdBank,
	output logic             wrStore,
	output logic [1:0]       wrBank,
	output logic             cmdError
);
	import sdpr_pkg::*;

	sdpr_top_s q;
	sdpr_top_s next_q;
	sdpr_cmd_e cmd;

	logic [3:0] bOpen;
	logic [3:0] bIdle;
	logic [3:0] bAuto;
	logic [3:0] act;
	logic [3:0] pre;
	logic [3:0] acc;
	logic [3:0] intr;
	logic       refBusy;
	sdpr_row_t  refRow;
	logic       refGo;
	logic       blCont;
	logic       wbm;
	logic [7:0] rdLen;
	logic [7:0] accLen;
	logic       autoOn;
	logic       rdGo;
	logic       wrGo;
	logic [1:0] clSel;

	////////////////////////////////////////////////////////////////////////
	// command decode
	always_comb begin
		cmd = SDPR_OTHER;
		if (cs_n || (ras_n && cas_n && we_n)) begin
			cmd = SDPR_NOP;
		end else if (!ras_n && cas_n && we_n) begin
			cmd = SDPR_ACT;
		end else if (ras_n && !cas_n && we_n) begin
			cmd = SDPR_RD;
		end else if (ras_n && !cas_n && !we_n) begin
			cmd = SDPR_WR;
		end else if (!ras_n && cas_n && !we_n) begin
			cmd = SDPR_PRE;
		end else if (!ras_n && !cas_n && we_n) begin
			cmd = SDPR_REF;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-bank requests
	always_comb begin
		blCont = q.cfg[`SDPR_CFG_BL_LSB +: 3] == `SDPR_BL_CONT;
		wbm    = q.cfg[`SDPR_CFG_WBM_BIT];
		rdLen  = 8'h01 << q.cfg[`SDPR_CFG_BL_LSB +: 2];
		accLen = (cmd == SDPR_WR && wbm) ? 8'h01 : rdLen; // RQ22
		autoOn = addr[`SDPR_AP_BIT]; // RQ7
		clSel  = q.cfg[`SDPR_CFG_CL_LSB +: 2];
		rdGo   = 1'b0;
		wrGo   = 1'b0;
		refGo  = 1'b0;
		act    = 4'h0;
		pre    = 4'h0;
		acc    = 4'h0;
		intr   = 4'h0;
		if (!refBusy) begin
			for (int i = 0; i < 4; i++) begin
				act[i]  = cmd == SDPR_ACT && ba == 2'(i) && bIdle[i]; // RQ3
				pre[i]  = cmd == SDPR_PRE &&
					(addr[`SDPR_AP_BIT] || ba == 2'(i)); // RQ1
				acc[i]  = (cmd == SDPR_RD || cmd == SDPR_WR) &&
					ba == 2'(i) && bOpen[i] && !bAuto[i]; // RQ2 RQ8
				intr[i] = (cmd == SDPR_RD || cmd == SDPR_WR) &&
					ba != 2'(i) && (acc != 4'h0 || bOpen[ba]);
			end
			rdGo  = cmd == SDPR_RD && acc != 4'h0;
			wrGo  = cmd == SDPR_WR && acc != 4'h0;
			refGo = cmd == SDPR_REF && bIdle == 4'hf; // RQ16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// four independent banks
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_bank // RQ23
			sdpr_bank #(
				.TRP  (T_RP_CYC),
				.TRAS (T_RAS_CYC),
				.TWR  (T_WR_CYC)
			) u_bank (
				.clk_sys     (clk_sys),
				.reset_n     (reset_n),
				.activate    (act[gb]),
				.precharge   (pre[gb]),
				.access      (acc[gb]),
				.accWrite    (cmd == SDPR_WR),
				.accAuto     (autoOn),
				.accCont     (blCont),
				.accLen      (accLen),
				.interrupt   (intr[gb]),
				.open        (bOpen[gb]),
				.idle        (bIdle[gb]),
				.autoPending (bAuto[gb])
			);
		end
	endgenerate

	sdpr_refresh #(
		.TRFC (T_RFC_CYC)
	) u_refresh (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.start   (refGo),
		.busy    (refBusy),
		.row     (refRow)
	);

	////////////////////////////////////////////////////////////////////////
	// data strobes, register port and error flag
	logic       rdIssue;
	logic       wrTake;
	logic [2:0] rdTap;
	logic [5:0] rdBankTap;
	logic [15:0] statWord;

	always_comb begin
		next_q = q;
		// read column issue; a write cuts the read at once
		rdIssue = rdGo || (q.rdLeft != 8'h00 && cmd != SDPR_WR); // RQ11
		if (rdGo) begin // RQ10
			next_q.rdLeft    = blCont ? 8'h01 : rdLen - 8'h01;
			next_q.rdCont    = blCont;
			next_q.rdCurBank = ba;
		end else if (cmd == SDPR_WR || pre[q.rdCurBank]) begin
			next_q.rdLeft = 8'h00;
		end else if (q.rdLeft != 8'h00 && !q.rdCont) begin
			next_q.rdLeft = q.rdLeft - 8'h01;
		end
		rdTap     = {q.rdPipe, rdIssue};
		rdBankTap = {q.rdBankPipe, (rdGo ? ba : q.rdCurBank)};
		if (cmd == SDPR_WR) begin // RQ11
			next_q.rdPipe = 2'b00;
		end else begin
			next_q.rdPipe = {q.rdPipe[0], rdIssue};
		end
		next_q.rdBankPipe = rdBankTap[3:0];
		// read data mask acts two clocks later
		next_q.dqmPipe = {q.dqmPipe[0], dqm}; // RQ12
		if (clSel == 2'h0) begin
			next_q.rdValid = 1'b0;
			next_q.rdBank  = 2'h0;
		end else begin
			next_q.rdValid = rdTap[clSel - 2'h1] && !q.dqmPipe[0] &&
				cmd != SDPR_WR; // RQ11
			next_q.rdBank  = rdBankTap[2 * (clSel - 2'h1) +: 2];
		end
		// write data: a read or a new write ends the old burst
		wrTake = wrGo || (q.wrLeft != 8'h00 && cmd != SDPR_RD &&
			cmd != SDPR_WR && !pre[q.wrCurBank]); // RQ14 RQ15
		if (wrGo) begin
			next_q.wrLeft    = blCont ? `SDPR_WR_CONT_LEN :
				accLen - 8'h01; // RQ6 RQ22
			next_q.wrCont    = blCont;
			next_q.wrCurBank = ba;
		end else if (!wrTake) begin
			next_q.wrLeft = 8'h00;
		end else if (!q.wrCont) begin
			next_q.wrLeft = q.wrLeft - 8'h01;
		end
		next_q.wrStore     = wrTake && !dqm;
		next_q.wrStoreBank = wrGo ? ba : q.wrCurBank;
		// illegal commands
		next_q.cmdError =
			(refBusy && cmd != SDPR_NOP) || // RQ18
			(cmd == SDPR_ACT && !bIdle[ba]) ||
			((cmd == SDPR_RD || cmd == SDPR_WR) && acc == 4'h0) || // RQ2 RQ8
			(cmd == SDPR_REF && bIdle != 4'hf); // RQ16
		// state mirrors
		next_q.open     = bOpen;
		next_q.idle     = bIdle;
		next_q.autoPend = bAuto;
		next_q.refBusy  = refBusy;
		next_q.refRow   = refRow;
		// register port
		statWord = {7'h00, refBusy, bIdle, bOpen};
		if (regWr && regAddr == `SDPR_REG_CFG) begin
			next_q.cfg = regWdata;
		end
		next_q.rdata = 16'h0000;
		if (regRd) begin
			case (regAddr)
				`SDPR_REG_CFG:  next_q.rdata = q.cfg;
				`SDPR_REG_STAT: next_q.rdata = statWord;
				`SDPR_REG_ROW:  next_q.rdata = {4'h0, refRow};
				default:        next_q.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q      <= '0;
			q.cfg  <= `SDPR_CFG_RESET;
			q.idle <= 4'hf;
		end else begin
			q <= next_q;
		end
	end

	assign regRdata        = q.rdata;
	assign bankOpen        = q.open;
	assign bankIdle        = q.idle;
	assign bankAutoPending = q.autoPend;
	assign refreshBusy     = q.refBusy;
	assign refreshRow      = q.refRow;
	assign rdValid         = q.rdValid;
	assign rdBank          = q.rdBank;
	assign wrStore         = q.wrStore;
	assign wrBank          = q.wrStoreBank;
	assign cmdError        = q.cmdError;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_wr_single;
		(wrGo && wbm && !blCont) ##1 (cmd != SDPR_WR);
	endsequence

	sequence s_rd_cut_wr;
		(cmd == SDPR_RD) ##1 (cmd != SDPR_WR);
	endsequence

	sequence s_wr_cut_rd;
		wrGo ##1 (cmd != SDPR_RD);
	endsequence

	pre_all_a: assert property ( // RQ1
		(cmd == SDPR_PRE && addr[`SDPR_AP_BIT] && !refBusy) |=>
			bOpen == 4'h0)
		else $error("precharge all left a bank open");

	pre_one_a: assert property ( // RQ1
		(cmd == SDPR_PRE && !addr[`SDPR_AP_BIT] && !refBusy) |=>
			((($past(bOpen & ~bAuto) & ~(4'h1 << $past(ba))) &
			~bOpen) == 4'h0 && !bOpen[$past(ba)]))
		else $error("single precharge hit the wrong bank");

	wr_single_a: assert property ( // RQ22
		s_wr_single |=> !q.wrStore)
		else $error("single write mode stored more than one column");

	rd_stops_wr_a: assert property ( // RQ14
		s_rd_cut_wr |-> (!q.wrStore ##1 !q.wrStore))
		else $error("write data stored after interrupting read");

	wr_cuts_rd_a: assert property ( // RQ11
		s_wr_cut_rd |=> !q.rdValid)
		else $error("read data after interrupting write");

	rd_latency_a: assert property ( // RQ10
		(rdGo && clSel == 2'h2 && !dqm ##1
			(!q.dqmPipe[0] && cmd != SDPR_WR)) |=>
			(q.rdValid && q.rdBank == $past(ba, 2)))
		else $error("read data not at CAS latency");

endmodule : sdpr_ctrl

// file: dv/sdpr_host.sv
// sdpr_host.sv: memory controller model driving the command pins
// assumes: shares clk_sys with the device; the bench calls issue()
module sdpr_host (
	// clock
	input  wire logic        clk_sys,
	// device state
	input  wire logic [3:0]  bankIdle,
	input  wire logic        refreshBusy,
	// command pins
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic [11:0]      addr,
	output logic [1:0]       ba,
	output logic             dqm
);
	timeunit 1ns;
	timeprecision 1ps;
	import sdpr_pkg::*;
	// refresh period; bench refreshes one command at a time
	localparam int REF_MS = 64;
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		addr = 12'h000;
		ba = 2'h0;
		dqm = 1'b0;
	end
	////////////////////////////////////////////////////////////////////
	// one command per call; nop only while waiting on bank or refresh state
	task automatic issue(input sdpr_cmd_e c, input logic [1:0] b,
		input logic a10, input logic m = 1'b0);
		logic [3:0] p;
		int         i;
		case (c)
		SDPR_ACT: p = 4'h3;
		SDPR_RD:  p = 4'h5;
		SDPR_WR:  p = 4'h4;
		SDPR_PRE: p = 4'h2;
		SDPR_REF: p = 4'h1;
		default:  p = 4'h7;
		endcase
		// bounded wait, then the command goes out regardless
		for (i = 0; i < 16 && c == SDPR_ACT &&
			(!bankIdle[b] || refreshBusy); i++)
			@(posedge clk_sys) {cs_n, ras_n, cas_n, we_n} <= 4'h7;
		for (i = 0; i < 16 && c == SDPR_REF &&
			(bankIdle != 4'hf || refreshBusy); i++)
			@(posedge clk_sys) {cs_n, ras_n, cas_n, we_n} <= 4'h7;
		@(posedge clk_sys);
		{cs_n, ras_n, cas_n, we_n} <= p;
		addr <= a10 ? 12'h4a5 : 12'h0a5;
		ba <= b;
		dqm <= m;
	endtask : issue
endmodule : sdpr_host

// file: dv/testbench.sv
// testbench.sv: self-checking bench of the bank-state logic
// assumes: sdpr_pkg, sdpr_ctrl and sdpr_host compiled before it
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sdpr_pkg::*;
	localparam int TRAS = 8;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        cs_n, ras_n, cas_n, we_n, dqm;
	logic [11:0] addr;
	logic [1:0]  ba, rdBank, wrBank;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdata, d;
	logic [3:0]  bankOpen, bankIdle, bankAutoPending;
	logic        refreshBusy, rdValid, wrStore, cmdError;
	sdpr_row_t   refreshRow, r0;
	int          errors = 0;
	int          n_compared = 0;
	int          cntWr [4];
	int          cntRd [4];
	int          cntErr, cntOpen;
	always #20 clk_sys = ~clk_sys;
	sdpr_ctrl #(.T_RAS_CYC(TRAS), .T_RFC_CYC(6)) dut_u (.clk_sys, .reset_n,
		.cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .dqm, .regAddr,
		.regWdata, .regWr, .regRd, .regRdata, .bankOpen, .bankIdle,
		.bankAutoPending, .refreshBusy, .refreshRow, .rdValid, .rdBank,
		.wrStore, .wrBank, .cmdError);
	sdpr_host host_u (.clk_sys, .bankIdle, .refreshBusy, .cs_n, .ras_n,
		.cas_n, .we_n, .addr, .ba, .dqm);
	////////////////////////////////////////////////////////////////////
	// beat, error and open-cycle counters
	always @(posedge clk_sys) begin
		if (wrStore === 1'b1) cntWr[wrBank]++;
		if (rdValid === 1'b1) cntRd[rdBank]++;
		if (cmdError === 1'b1) cntErr++;
		if (bankOpen[0] === 1'b1) cntOpen++;
	end
	task automatic chkv(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask : chkv
	task automatic chkn(input int g, input int e);
		n_compared++;
		if (g != e) begin
			errors++;
			$display("[ERR] %0t count %0d expected %0d", $time, g, e);
		end
	endtask : chkn
	task automatic regW(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : regW
	task automatic regR(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		v = regRdata;
	endtask : regR
	task automatic go(sdpr_cmd_e c, logic [1:0] b, logic a, logic m = 0);
		host_u.issue(c, b, a, m);
	endtask : go
	task automatic idle(input int n);
		repeat (n) go(SDPR_NOP, 2'h0, 1'b0);
	endtask : idle
	task automatic look(input int n);
		idle(n);
		@(negedge clk_sys);
	endtask : look
	task automatic clear;
		foreach (cntWr[i]) begin
			cntWr[i] = 0;
			cntRd[i] = 0;
		end
		cntErr = 0;
		cntOpen = 0;
	endtask : clear
	// close all, open banks 0 and 1
	task automatic reopen;
		go(SDPR_PRE, 2'h2, 1'b1);
		go(SDPR_ACT, 2'h0, 1'b0);
		go(SDPR_ACT, 2'h1, 1'b0);
		idle(2);
		clear();
	endtask : reopen
	task automatic close_out;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(negedge clk_sys);
		chkv(16'(bankIdle), 16'h000f);
		regR(4'h0, d);
		chkv(d, 16'h0022);
		regW(4'h4, 16'hffff);
		regR(4'h4, d);
		chkv(d, 16'h00f0);
		regR(4'hc, d);
		chkv(d, 16'h0000);
		clear();
		go(SDPR_RD, 2'h0, 1'b0);
		look(3);
		chkn(cntErr, 1);
		for (int b = 0; b < 4; b++) go(SDPR_ACT, 2'(b), 1'b0);
		look(TRAS + 2);
		chkv(16'(bankOpen), 16'h000f);
		go(SDPR_PRE, 2'h1, 1'b0);
		look(3);
		chkv(16'(bankOpen), 16'h000d);
		go(SDPR_PRE, 2'h2, 1'b1);
		look(4);
		chkv(16'(bankIdle), 16'h000f);
		regW(4'h0, 16'h0020);
		clear();
		go(SDPR_ACT, 2'h0, 1'b0);
		idle(2);
		go(SDPR_RD, 2'h0, 1'b1);
		look(16);
		chkn(int'(cntOpen >= TRAS), 1);
		regW(4'h0, 16'h0022);
		go(SDPR_ACT, 2'h0, 1'b0);
		idle(2);
		clear();
		go(SDPR_WR, 2'h0, 1'b1);
		look(16);
		chkn(cntWr[0], 4);
		chkv(16'(bankIdle), 16'h000f);
		go(SDPR_ACT, 2'h0, 1'b0);
		idle(2);
		go(SDPR_WR, 2'h0, 1'b0);
		look(16);
		chkv(16'(bankOpen), 16'h0001);
		regW(4'h0, 16'h0027);
		go(SDPR_RD, 2'h0, 1'b1);
		look(16);
		chkv(16'(bankAutoPending), 16'h0000);
		chkv(16'(bankOpen), 16'h0001);
		regW(4'h0, 16'h0022);
		go(SDPR_RD, 2'h0, 1'b0);
		idle(8);
		regW(4'h0, 16'h0227);
		go(SDPR_WR, 2'h0, 1'b1);
		look(16);
		chkv(16'(bankOpen), 16'h0001);
		regW(4'h0, 16'h0022);
		go(SDPR_WR, 2'h0, 1'b0);
		idle(8);
		regW(4'h0, 16'h0222);
		clear();
		go(SDPR_WR, 2'h0, 1'b0);
		idle(8);
		go(SDPR_RD, 2'h0, 1'b0);
		look(10);
		chkn(cntWr[0], 1);
		chkn(cntRd[0], 4);
		regW(4'h0, 16'h0022);
		reopen();
		go(SDPR_RD, 2'h0, 1'b1);
		go(SDPR_RD, 2'h1, 1'b0);
		look(16);
		chkn(cntRd[0], 1);
		chkv(16'(bankOpen), 16'h0002);
		reopen();
		go(SDPR_NOP, 2'h0, 1'b0, 1'b1);
		go(SDPR_RD, 2'h0, 1'b1);
		go(SDPR_WR, 2'h1, 1'b0);
		look(16);
		chkn(cntRd[0], 0);
		chkn(cntWr[1], 4);
		chkv(16'(bankOpen), 16'h0002);
		reopen();
		go(SDPR_WR, 2'h0, 1'b1);
		go(SDPR_NOP, 2'h0, 1'b0);
		go(SDPR_RD, 2'h1, 1'b0);
		look(16);
		chkn(cntWr[0], 2);
		chkn(cntRd[1], 4);
		chkv(16'(bankOpen), 16'h0002);
		reopen();
		go(SDPR_WR, 2'h0, 1'b1);
		go(SDPR_WR, 2'h1, 1'b0);
		look(16);
		chkn(cntWr[0], 1);
		chkv(16'(bankOpen), 16'h0002);
		clear();
		go(SDPR_REF, 2'h0, 1'b0);
		look(3);
		chkn(cntErr, 1);
		go(SDPR_PRE, 2'h0, 1'b1);
		go(SDPR_REF, 2'h0, 1'b0);
		look(12);
		r0 = refreshRow;
		clear();
		go(SDPR_REF, 2'h3, 1'b1);
		go(SDPR_NOP, 2'h0, 1'b0);
		go(SDPR_ACT, 2'h0, 1'b0);
		look(3);
		chkn(cntErr, 1);
		chkv(16'(refreshBusy), 16'h0001);
		chkn(int'(refreshRow !== r0), 1);
		close_out();
	end
endmodule : testbench
